// ==== core/cen_notifier.sv ====
// Contract
// - message on enabled input line 1-4 change
// - message on enabled pulse start, lines 3-6
// - queue overflow disables all, sends overflow event
// - per-source setting: off, on, legacy format
// - input line edge: rise, fall or both
// - edge setting only for inputs; outputs pulse-start
// - statistic selector picks shown occurrence count
// - enabled acquisition start and end events
// - frame begin fires at exposure delay start
// - frame finish event on active frame end
// - event per accepted frame trigger
// - rejected frame trigger gives reject event
// - image dropped for memory gives event
// - rejected line trigger gives reject event
// - postponed line trigger gives overlap event
// - per-source count, read and reset selected
// - message carries 64-bit timestamp at occurrence
`timescale 1ns/100ps
`default_nettype none
module cen_notifier #(
   parameter int DEPTH  = 8,
   parameter int CNT_W  = 32
) (
   // clock and reset
   input  wire logic                              hclk,
   input  wire logic                              hresetn,
   // ahb-lite slave
   input  wire logic                              hsel,
   input  wire logic [31:0]                       haddr,
   input  wire logic [1:0]                        htrans,
   input  wire logic                              hwrite,
   input  wire logic [2:0]                        hsize,
   input  wire logic [31:0]                       hwdata,
   input  wire logic                              hready,
   output logic      [31:0]                       hrdata,
   output logic                                   hreadyout,
   output logic                                   hresp,
   // event sources: engine and pulse-start are one-cycle pulses on hclk, io lines are levels, plus the timestamp
   input  wire logic [cen_pkg::NUM_ENGINE-1:0]    engine_evt,
   input  wire logic [cen_pkg::NUM_PULSE_LINES-1:0] pulse_start,
   input  wire logic [cen_pkg::NUM_IN_LINES-1:0]  io_line,
   input  wire logic [63:0]                       ts_value,
   // message channel to the control link
   output logic                                   msg_valid,
   output cen_pkg::cen_msg_t                      msg,
   input  wire logic                              msg_ready,
   // interrupt
   output logic                                   irq
);

   localparam int N  = cen_pkg::NUM_SRC;
   localparam int PW = $clog2(DEPTH);

   // ************************************************************
   // ahb-lite slave
   // ************************************************************
   logic                       ph_wr_q;
   logic                       ph_rd_q;
   logic [cen_pkg::ADDR_W-1:0] ph_addr_q;
   cen_pkg::cen_ahb_state_t    ahb_q;
   cen_pkg::cen_ahb_state_t    ahb_d;
   logic [31:0]                hrdata_q;
   logic [31:0]                hrdata_d;
   logic                       hreadyout_q;

   wire acc_ok   = hsel & hready & (htrans == cen_pkg::HTRANS_NONSEQ) & (hsize == cen_pkg::HSIZE_WORD);
   wire acc_wr   = acc_ok & hwrite;
   wire acc_rd   = acc_ok & ~hwrite;
   wire wr_now   = ph_wr_q;
   wire wr_sel   = wr_now & (ph_addr_q == cen_pkg::REG_SRC_SEL);
   wire wr_ntf   = wr_now & (ph_addr_q == cen_pkg::REG_NOTIFY);
   wire wr_lcfg  = wr_now & (ph_addr_q == cen_pkg::REG_LINE_CFG);
   wire wr_ssel  = wr_now & (ph_addr_q == cen_pkg::REG_STAT_SEL);
   wire wr_scnt  = wr_now & (ph_addr_q == cen_pkg::REG_STAT_COUNT);
   wire wr_ist   = wr_now & (ph_addr_q == cen_pkg::REG_IRQ_STATUS);
   wire wr_imsk  = wr_now & (ph_addr_q == cen_pkg::REG_IRQ_MASK);

   // reads wait one cycle so a write in the previous data phase is seen
   always_comb begin
      ahb_d = ahb_q;
      case (ahb_q)
         cen_pkg::CEN_AHB_IDLE: begin
            if (acc_rd) begin
               ahb_d = cen_pkg::CEN_AHB_READ;
            end
         end
         cen_pkg::CEN_AHB_READ: begin
            ahb_d = cen_pkg::CEN_AHB_IDLE;
         end
         default: begin
            ahb_d = cen_pkg::CEN_AHB_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_q     <= 1'b0;
         ph_rd_q     <= 1'b0;
         ph_addr_q   <= '0;
         ahb_q       <= cen_pkg::CEN_AHB_IDLE;
         hreadyout_q <= 1'b1;
         hrdata_q    <= '0;
      end else begin
         ph_wr_q     <= acc_wr;
         ph_rd_q     <= acc_rd;
         if (acc_ok) begin
            ph_addr_q <= haddr[cen_pkg::ADDR_W-1:0];
         end
         ahb_q       <= ahb_d;
         hreadyout_q <= (ahb_d == cen_pkg::CEN_AHB_IDLE);
         hrdata_q    <= hrdata_d;
      end
   end

   assign hreadyout = hreadyout_q;
   assign hrdata    = hrdata_q;
   assign hresp     = 1'b0;

   // ************************************************************
   // control registers
   // ************************************************************
   logic [cen_pkg::SRC_W-1:0] src_sel_q;
   logic [cen_pkg::SRC_W-1:0] stat_sel_q;
   logic [11:0]               line_cfg_q;
   logic [cen_pkg::IRQ_W-1:0] irq_stat_q;
   logic [cen_pkg::IRQ_W-1:0] irq_mask_q;
   logic                      irq_q;
   logic [1:0]                notify_q [N];
   logic [CNT_W-1:0]          count_q  [N];
   logic [63:0]               stamp_q  [N];
   logic [N-1:0]              pend_q;
   logic [N-1:0]              fire;
   logic [N-1:0]              grant;
   logic                      overrun;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_sel_q  <= '0;
         stat_sel_q <= '0;
         line_cfg_q <= cen_pkg::LINE_CFG_RESET;
         irq_mask_q <= '0;
      end else begin
         if (wr_sel) begin
            src_sel_q <= hwdata[cen_pkg::SRC_W-1:0];
         end
         if (wr_ssel) begin
            stat_sel_q <= hwdata[cen_pkg::SRC_W-1:0];
         end
         if (wr_lcfg) begin
            line_cfg_q <= hwdata[11:0];
         end
         if (wr_imsk) begin
            irq_mask_q <= hwdata[cen_pkg::IRQ_W-1:0];
         end
      end
   end

   // ************************************************************
   // input lines: synchronise then detect edges
   // ************************************************************
   logic [cen_pkg::NUM_IN_LINES-1:0] line_s1_q;
   logic [cen_pkg::NUM_IN_LINES-1:0] line_s2_q;
   logic [cen_pkg::NUM_IN_LINES-1:0] line_prev_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_s1_q   <= '0;
         line_s2_q   <= '0;
         line_prev_q <= '0;
      end else begin
         line_s1_q   <= io_line;
         line_s2_q   <= line_s1_q;
         line_prev_q <= line_s2_q;
      end
   end

   // engine pulses map straight onto their sources
   assign fire[cen_pkg::NUM_ENGINE-1:0] = engine_evt;

   genvar gl;
   generate
      for (gl = 0; gl < cen_pkg::NUM_IN_LINES; gl++) begin : g_line
         wire [1:0] edge_sel = line_cfg_q[gl*cen_pkg::LCFG_STRIDE +: 2];
         wire       is_out   = line_cfg_q[gl*cen_pkg::LCFG_STRIDE + cen_pkg::LCFG_DIR_BIT];
         wire       rise     = line_s2_q[gl] & ~line_prev_q[gl];
         wire       fall     = ~line_s2_q[gl] & line_prev_q[gl];
         wire       hit      = ((edge_sel == cen_pkg::EDGE_RISE) & rise)
                             | ((edge_sel == cen_pkg::EDGE_FALL) & fall)
                             | ((edge_sel == cen_pkg::EDGE_BOTH) & (rise | fall));
         // an output-configured line reports only through its pulse-start source
         assign fire[cen_pkg::SRC_IO1_CHANGE + gl] = hit & ~is_out;
         assign fire[cen_pkg::SRC_IO3_PULSE + gl]  = pulse_start[gl];
      end
   endgenerate

   // ************************************************************
   // per-source pending slot, timestamp, setting and counter
   // ************************************************************
   logic [N-1:0] enabled;
   logic [N-1:0] collide;

   // a second occurrence before the first reached the queue overwrites the first in its slot
   assign overrun = |collide;
   // the overrun source raises itself even though every source is off
   assign fire[cen_pkg::SRC_OVERRUN] = overrun;

   genvar gs;
   generate
      for (gs = 0; gs < N; gs++) begin : g_src
         wire sel_me  = (src_sel_q == cen_pkg::SRC_W'(gs));
         wire stat_me = (stat_sel_q == cen_pkg::SRC_W'(gs));
         wire take    = (gs == cen_pkg::SRC_OVERRUN) ? (fire[gs] & ~pend_q[gs]) : (fire[gs] & enabled[gs]);
         assign enabled[gs] = (notify_q[gs] != cen_pkg::NOTIFY_OFF);
         assign collide[gs] = (gs != cen_pkg::SRC_OVERRUN) && (fire[gs] & enabled[gs] & pend_q[gs] & ~grant[gs]);

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               notify_q[gs] <= cen_pkg::NOTIFY_OFF;
               pend_q[gs]   <= 1'b0;
               stamp_q[gs]  <= '0;
               count_q[gs]  <= '0;
            end else begin
               if (overrun) begin
                  notify_q[gs] <= cen_pkg::NOTIFY_OFF;
               end else if (wr_ntf && sel_me) begin
                  notify_q[gs] <= hwdata[1:0];
               end
               if (take) begin
                  pend_q[gs]  <= 1'b1;
                  stamp_q[gs] <= ts_value;
               end else if (grant[gs]) begin
                  pend_q[gs]  <= 1'b0;
               end
               // a fresh occurrence in the reset cycle is counted, not lost
               if (wr_scnt && stat_me) begin
                  count_q[gs] <= fire[gs] ? CNT_W'(1) : '0;
               end else if (fire[gs]) begin
                  count_q[gs] <= count_q[gs] + CNT_W'(1);
               end
            end
         end
      end
   endgenerate

   // ************************************************************
   // message queue
   // ************************************************************
   cen_pkg::cen_msg_t mem_q [DEPTH];
   logic [PW-1:0]     wptr_q;
   logic [PW-1:0]     rptr_q;
   logic [PW:0]       used_q;
   logic              msg_valid_q;
   cen_pkg::cen_msg_t msg_q;
   logic [4:0]        gidx;
   logic              gany;

   wire q_full  = (used_q == (PW+1)'(DEPTH));
   wire q_empty = (used_q == '0);
   wire pop     = ~q_empty & (~msg_valid_q | msg_ready);
   wire push    = gany;

   // highest index wins so the overrun report goes out first;
   // a full queue holds every source in its pending slot
   always_comb begin
      gidx  = '0;
      gany  = 1'b0;
      grant = '0;
      for (int i = 0; i < N; i++) begin
         if (pend_q[i] && !q_full) begin
            gidx = 5'(i);
            gany = 1'b1;
         end
      end
      if (gany) begin
         grant[gidx] = 1'b1;
      end
   end

   wire cen_pkg::cen_msg_t push_msg = '{src:    gidx,
                                        legacy: (notify_q[gidx] == cen_pkg::NOTIFY_LEGACY),
                                        stamp:  stamp_q[gidx]};

   always_ff @(posedge hclk) begin
      if (push) begin
         mem_q[wptr_q] <= push_msg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wptr_q      <= '0;
         rptr_q      <= '0;
         used_q      <= '0;
         msg_valid_q <= 1'b0;
         msg_q       <= '0;
      end else begin
         if (push) begin
            wptr_q <= (wptr_q == PW'(DEPTH-1)) ? '0 : wptr_q + PW'(1);
         end
         if (pop) begin
            rptr_q <= (rptr_q == PW'(DEPTH-1)) ? '0 : rptr_q + PW'(1);
            msg_q  <= mem_q[rptr_q];
         end
         used_q <= used_q + (PW+1)'(push) - (PW+1)'(pop);
         if (pop) begin
            msg_valid_q <= 1'b1;
         end else if (msg_ready) begin
            msg_valid_q <= 1'b0;
         end
      end
   end

   assign msg_valid = msg_valid_q;
   assign msg       = msg_q;

   // ************************************************************
   // interrupt status, write one to clear, set wins
   // ************************************************************
   wire [cen_pkg::IRQ_W-1:0] irq_set = {msg_valid_q & msg_ready, overrun};
   wire [cen_pkg::IRQ_W-1:0] irq_clr = wr_ist ? hwdata[cen_pkg::IRQ_W-1:0] : '0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_q <= '0;
         irq_q      <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
         irq_q      <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
      end
   end

   assign irq = irq_q;

   // ************************************************************
   // read mux, evaluated in the wait cycle of a read
   // ************************************************************
   always_comb begin
      hrdata_d = '0;
      if (ph_rd_q) begin
         case (ph_addr_q)
            cen_pkg::REG_SRC_SEL:    hrdata_d = 32'(src_sel_q);
            cen_pkg::REG_NOTIFY:     hrdata_d = (src_sel_q < 5'(N)) ? 32'(notify_q[src_sel_q]) : '0;
            cen_pkg::REG_LINE_CFG:   hrdata_d = 32'(line_cfg_q);
            cen_pkg::REG_STAT_SEL:   hrdata_d = 32'(stat_sel_q);
            cen_pkg::REG_STAT_COUNT: hrdata_d = (stat_sel_q < 5'(N)) ? 32'(count_q[stat_sel_q]) : '0;
            cen_pkg::REG_IRQ_STATUS: hrdata_d = 32'(irq_stat_q);
            cen_pkg::REG_IRQ_MASK:   hrdata_d = 32'(irq_mask_q);
            default:                 hrdata_d = '0;
         endcase
      end
   end

endmodule
`default_nettype wire

// ==== core/cen_pkg.sv ====
package cen_pkg;

   // ************************************************************
   // event sources, also the source_select and stat_source_select codes
   // ************************************************************
   localparam int          NUM_SRC                 = 18;
   localparam int          SRC_W                   = 5;
   localparam int          NUM_ENGINE              = 9;
   localparam int          NUM_IN_LINES            = 4;
   localparam int          NUM_PULSE_LINES         = 4;
   localparam logic [4:0]  SRC_ACQ_BEGIN           = 5'h00;
   localparam logic [4:0]  SRC_ACQ_FINISH          = 5'h01;
   localparam logic [4:0]  SRC_FRAME_BEGIN         = 5'h02;
   localparam logic [4:0]  SRC_FRAME_FINISH        = 5'h03;
   localparam logic [4:0]  SRC_FRAME_TRIG_OK       = 5'h04;
   localparam logic [4:0]  SRC_FRAME_TRIG_REJECT   = 5'h05;
   localparam logic [4:0]  SRC_IMAGE_DROP          = 5'h06;
   localparam logic [4:0]  SRC_LINE_TRIG_REJECT    = 5'h07;
   localparam logic [4:0]  SRC_LINE_TRIG_POSTPONED = 5'h08;
   localparam int          SRC_IO1_CHANGE          = 9;
   localparam int          SRC_IO3_PULSE           = 13;
   localparam int          SRC_OVERRUN             = 17;

   // ************************************************************
   // setting encodings
   // ************************************************************
   localparam logic [1:0]  NOTIFY_OFF              = 2'h0;
   localparam logic [1:0]  NOTIFY_ON               = 2'h1;
   localparam logic [1:0]  NOTIFY_LEGACY           = 2'h2;
   localparam logic [1:0]  EDGE_RISE               = 2'h0;
   localparam logic [1:0]  EDGE_FALL               = 2'h1;
   localparam logic [1:0]  EDGE_BOTH               = 2'h2;

   // ************************************************************
   // register map, byte addresses
   // ************************************************************
   localparam logic [7:0]  REG_SRC_SEL             = 8'h00;
   localparam logic [7:0]  REG_NOTIFY              = 8'h04;
   localparam logic [7:0]  REG_LINE_CFG            = 8'h08;
   localparam logic [7:0]  REG_STAT_SEL            = 8'h0C;
   localparam logic [7:0]  REG_STAT_COUNT          = 8'h10;
   localparam logic [7:0]  REG_IRQ_STATUS          = 8'h14;
   localparam logic [7:0]  REG_IRQ_MASK            = 8'h18;
   localparam int          ADDR_W                  = 8;
   localparam int          LCFG_STRIDE             = 3;
   localparam int          LCFG_DIR_BIT            = 2;
   localparam int          IRQ_W                   = 2;
   localparam int          IRQ_OVERRUN_BIT         = 0;
   localparam int          IRQ_SENT_BIT            = 1;
   localparam logic [11:0] LINE_CFG_RESET          = 12'h000;
   localparam logic [1:0]  HTRANS_NONSEQ           = 2'h2;
   localparam logic [2:0]  HSIZE_WORD              = 3'h2;

   typedef enum logic [0:0] {
      CEN_AHB_IDLE = 1'b0,
      CEN_AHB_READ = 1'b1
   } cen_ahb_state_t;

   typedef struct packed {
      logic [4:0]  src;
      logic        legacy;
      logic [63:0] stamp;
   } cen_msg_t;

endpackage

// ==== testbench/cen_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module cen_host_model (
   // clock and reset
   input wire logic              hclk,
   input wire logic              hresetn,
   // stall request from the bench
   input wire logic              stall,
   // message channel
   input wire logic              msg_valid,
   input wire cen_pkg::cen_msg_t msg,
   output logic                  msg_ready
);
   // ********
   // receiver
   // ********
   cen_pkg::cen_msg_t rx_q[$];
   // a message counts as taken only on an edge where both sides are high
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         msg_ready <= 1'b0;
      end else begin
         msg_ready <= !stall;
         if (msg_valid && msg_ready) begin
            rx_q.push_back(msg);
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/cen_notifier_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module cen_notifier_sva #(
   parameter int DEPTH = 8,
   parameter int CNT_W = 32
) (
   // clock and reset
   input wire logic                    hclk,
   input wire logic                    hresetn,
   // ahb-lite
   input wire logic                    hsel,
   input wire logic [31:0]             haddr,
   input wire logic [1:0]              htrans,
   input wire logic                    hwrite,
   input wire logic [2:0]              hsize,
   input wire logic [31:0]             hwdata,
   input wire logic                    hready,
   input wire logic [31:0]             hrdata,
   input wire logic                    hreadyout,
   input wire logic                    hresp,
   // events
   input wire logic [8:0]              engine_evt,
   input wire logic [3:0]              pulse_start,
   input wire logic [3:0]              io_line,
   input wire logic [63:0]             ts_value,
   // messages and interrupt
   input wire logic                    msg_valid,
   input wire cen_pkg::cen_msg_t       msg,
   input wire logic                    msg_ready,
   input wire logic                    irq
);
   // ********
   // helpers
   // ********
   wire logic take;
   wire logic rd_take;
   wire logic wr_take;
   assign take = hsel && hready && htrans == cen_pkg::HTRANS_NONSEQ && hsize == cen_pkg::HSIZE_WORD;
   assign rd_take = take && !hwrite;
   assign wr_take = take && hwrite;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   AST_HRESP_OKAY: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   AST_RD_WAIT: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   AST_WR_NOWAIT: assert property (wr_take |=> hreadyout)
      else $error("write stalled");
   AST_WAIT_CAUSE: assert property ($fell(hreadyout) |-> $past(rd_take))
      else $error("wait state without read");
   AST_MSG_HOLD: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg))
      else $error("message changed before taken");
   AST_MSG_DROP: assert property ($fell(msg_valid) |-> $past(msg_ready))
      else $error("message withdrawn");
   AST_SRC_RANGE: assert property (msg_valid |-> msg.src < 5'h12)
      else $error("bad source code");
   AST_OVR_PLAIN: assert property (msg_valid && msg.src == 5'h11 |-> !msg.legacy)
      else $error("overflow message legacy");
   AST_RESET_IDLE: assert property ($rose(hresetn) |-> !msg_valid && !irq && hreadyout)
      else $error("outputs not idle after reset");
   C_OVR: cover property (msg_valid && msg.src == 5'h11);
   C_RD: cover property (rd_take ##2 hreadyout);
   C_LEG: cover property (msg_valid && msg.legacy);
endmodule
bind cen_notifier cen_notifier_sva #(.DEPTH(DEPTH), .CNT_W(CNT_W)) u_sva (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .engine_evt(engine_evt), .pulse_start(pulse_start), .io_line(io_line),
   .ts_value(ts_value), .msg_valid(msg_valid), .msg(msg), .msg_ready(msg_ready), .irq(irq));
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic              hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic              msg_valid, msg_ready, irq, stall;
   logic [31:0]       haddr, hwdata, hrdata;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [8:0]        engine_evt;
   logic [3:0]        pulse_start, io_line;
   logic [63:0]       ts_value;
   cen_pkg::cen_msg_t msg;
   int                err_count, comparisons, n17;
   logic [11:0]       cfg_tab [7] = '{12'h492, 12'h492, 12'h492, 12'h492, 12'h000, 12'h001, 12'h006};
   int                exp_tab [7] = '{2, 2, 2, 2, 1, 1, 0};
   assign hready = hreadyout;
   cen_notifier #(.DEPTH(2), .CNT_W(32)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .engine_evt(engine_evt), .pulse_start(pulse_start), .io_line(io_line),
      .ts_value(ts_value), .msg_valid(msg_valid), .msg(msg), .msg_ready(msg_ready), .irq(irq));
   cen_host_model host (.hclk(hclk), .hresetn(hresetn), .stall(stall), .msg_valid(msg_valid),
      .msg(msg), .msg_ready(msg_ready));
   // ********
   // tasks
   // ********
   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // master holds each phase until hready is seen high at an edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      htrans <= cen_pkg::HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(72'(q), 72'(e));
   endtask
   task automatic fire(input logic [8:0] e, input logic [3:0] p);
      engine_evt <= e;
      pulse_start <= p;
      @(posedge hclk);
      engine_evt <= 9'h000;
      pulse_start <= 4'h0;
      @(posedge hclk);
   endtask
   task automatic expect_msg(input logic [4:0] s, input logic l);
      cen_pkg::cen_msg_t m;
      for (int i = 0; i < 60 && host.rx_q.size() == 0; i++) @(posedge hclk);
      check(72'(host.rx_q.size() > 0), 72'h1);
      if (host.rx_q.size() > 0) begin
         m = host.rx_q.pop_front();
         check({2'h0, m.src, m.legacy, m.stamp}, {2'h0, s, l, ts_value});
      end
   endtask
   task automatic expect_count(input int n);
      repeat (30) @(posedge hclk);
      check(72'(host.rx_q.size()), 72'(n));
      host.rx_q.delete();
   endtask
   task automatic end_of_test;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   // a full run needs well under 5000 cycles
   initial begin
      #500us;
      err_count++;
      end_of_test();
   end
   // ********
   // sequence
   // ********
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = cen_pkg::HSIZE_WORD;
      engine_evt = 9'h000;
      pulse_start = 4'h0;
      io_line = 4'h0;
      ts_value = 64'h0000_0000_0000_0055;
      stall = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0);
      for (int i = 0; i < 9; i++) begin
         wr(cen_pkg::REG_SRC_SEL, 32'(i));
         wr(cen_pkg::REG_NOTIFY, (i % 2) ? 32'(cen_pkg::NOTIFY_LEGACY) : 32'(cen_pkg::NOTIFY_ON));
         ts_value <= 64'h0000_0000_0000_0100 + 64'(i);
         fire(9'(1 << i), 4'h0);
         expect_msg(5'(i), 1'(i % 2));
      end
      // same-cycle pair leaves the higher source first
      fire(9'h003, 4'h0);
      expect_msg(5'h01, 1'b1);
      expect_msg(5'h00, 1'b0);
      wr(cen_pkg::REG_SRC_SEL, 32'h0);
      wr(cen_pkg::REG_NOTIFY, 32'(cen_pkg::NOTIFY_OFF));
      fire(9'h001, 4'h0);
      expect_count(0);
      wr(cen_pkg::REG_STAT_SEL, 32'h0);
      rd(cen_pkg::REG_STAT_COUNT, 32'h3);
      wr(cen_pkg::REG_STAT_COUNT, 32'h0);
      rd(cen_pkg::REG_STAT_COUNT, 32'h0);
      wr(cen_pkg::REG_STAT_SEL, 32'h5);
      rd(cen_pkg::REG_STAT_COUNT, 32'h1);
      for (int k = 0; k < 4; k++) begin
         wr(cen_pkg::REG_SRC_SEL, 32'(cen_pkg::SRC_IO3_PULSE + k));
         wr(cen_pkg::REG_NOTIFY, 32'(cen_pkg::NOTIFY_ON));
         fire(9'h000, 4'(1 << k));
         expect_msg(5'(cen_pkg::SRC_IO3_PULSE + k), 1'b0);
      end
      for (int k = 0; k < 4; k++) begin
         wr(cen_pkg::REG_SRC_SEL, 32'(cen_pkg::SRC_IO1_CHANGE + k));
         wr(cen_pkg::REG_NOTIFY, 32'(cen_pkg::NOTIFY_ON));
      end
      // both edges on every line, then rise, fall and output mode on line 1
      for (int c = 0; c < 7; c++) begin
         wr(cen_pkg::REG_LINE_CFG, 32'(cfg_tab[c]));
         // the last three settings all exercise line 1, whose config bits are the low ones
         io_line[(c > 3) ? 0 : c] <= 1'b1;
         repeat (8) @(posedge hclk);
         io_line[(c > 3) ? 0 : c] <= 1'b0;
         expect_count(exp_tab[c]);
      end
      rd(cen_pkg::REG_IRQ_STATUS, 32'h2);
      check(72'(irq), 72'h0);
      wr(cen_pkg::REG_IRQ_MASK, 32'h2);
      repeat (2) @(posedge hclk);
      check(72'(irq), 72'h1);
      wr(cen_pkg::REG_IRQ_STATUS, 32'h2);
      repeat (2) @(posedge hclk);
      check(72'(irq), 72'h0);
      // host stalls so the depth-2 queue backs up into an overrun
      wr(cen_pkg::REG_IRQ_MASK, 32'h1);
      wr(cen_pkg::REG_SRC_SEL, 32'h0);
      wr(cen_pkg::REG_NOTIFY, 32'(cen_pkg::NOTIFY_ON));
      stall <= 1'b1;
      repeat (7) fire(9'h001, 4'h0);
      rd(cen_pkg::REG_NOTIFY, 32'h0);
      wr(cen_pkg::REG_SRC_SEL, 32'(cen_pkg::SRC_IO1_CHANGE));
      rd(cen_pkg::REG_NOTIFY, 32'h0);
      check(72'(irq), 72'h1);
      stall <= 1'b0;
      repeat (40) @(posedge hclk);
      n17 = 0;
      foreach (host.rx_q[j]) if (host.rx_q[j].src == 5'h11) n17++;
      check(72'(n17), 72'h1);
      // held output, two queued, one pending, plus the overflow report
      expect_count(5);
      fire(9'h001, 4'h0);
      expect_count(0);
      wr(cen_pkg::REG_SRC_SEL, 32'h0);
      wr(cen_pkg::REG_NOTIFY, 32'(cen_pkg::NOTIFY_ON));
      fire(9'h001, 4'h0);
      expect_msg(5'h00, 1'b0);
      wr(cen_pkg::REG_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge hclk);
      check(72'(irq), 72'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
